// ### rrf_bit_shifter.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// byte to bit shifter, lsb first
// ************************************************************
module rrf_bit_shifter
    import rrf_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // byte side
    input wire logic load_in,
    input wire logic [7:0] byte_in,
    // bit side
    input wire logic adv_in,
    output logic bit_out,
    output logic last_out
);

    logic [7:0] sh_r;
    logic [2:0] cnt_r;

    // shift right so bit 0 leaves first
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            sh_r <= RRF_FLAGS_RST;
            cnt_r <= 3'h0;
        end
        else if (load_in)
        begin
            sh_r <= byte_in;
            cnt_r <= 3'h0;
        end
        else if (adv_in)
        begin
            sh_r <= {1'b0, sh_r[7:1]};
            cnt_r <= cnt_r + 3'h1;
        end
    end

    assign bit_out = sh_r[0];
    assign last_out = (cnt_r == RRF_BIT_LAST);

endmodule : rrf_bit_shifter
`default_nettype wire

// ### rrf_flags_top.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - flag byte is eight bits, bit8 zero
// - bit3 selects meaning of bits five-eight
// - bit1 chooses one or two subcarriers
// - bit2 chooses low or high rate
// - bit5 non-inventory: execute only when selected
// - bit6 non-inventory: serial present, must match
// - bit5 inventory: family code field present
// - response: sof flags data crc eof; this block serialises only the flags byte and the error code
// - response bit1 flags error, code follows
// - response bits two to eight zero
// - bit6 inventory: one or sixteen slots
// - fields go lsb first, bytes lsb first
// - unsupported option reports error code 03h
module rrf_flags_top
    import rrf_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    // received request flag byte
    input wire logic REQ_VALID_IN,
    input wire logic [7:0] REQ_FLAGS_IN,
    // tag context
    input wire logic SELECTED_STATE_IN,
    input wire logic SERIAL_MATCH_IN,
    // decoded request, held until the next byte; EXECUTE_OUT also follows the live tag context
    output logic TWO_SUBCARRIERS_OUT,
    output logic HIGH_RATE_OUT,
    output logic INVENTORY_OUT,
    output logic SELECT_ONLY_OUT,
    output logic SERIAL_PRESENT_OUT,
    output logic OPTION_ON_OUT,
    output logic FAMILY_FIELD_PRESENT_OUT,
    output logic SLOT_COUNT_SELECT_OUT,
    output logic [4:0] SLOT_COUNT_OUT,
    output logic EXECUTE_OUT,
    output logic UNSUPPORTED_OUT,
    // response request
    input wire logic RESP_START_IN,
    input wire logic RESP_ERROR_IN,
    input wire logic [7:0] RESP_ERR_CODE_IN,
    output logic RESP_BUSY_OUT,
    // response bit stream
    input wire logic BIT_READY_IN,
    output logic BIT_VALID_OUT,
    output logic BIT_DATA_OUT,
    output logic BYTE_LAST_OUT,
    output logic RESP_DONE_OUT
);

    // ************************************************************
    // request side
    // ************************************************************
    rrf_req_t dec_w;
    rrf_req_t req_r;
    logic valid_r;

    rrf_req_decode u_dec (
        .flags_in(REQ_FLAGS_IN),
        .req_out(dec_w)
    );

    // capture so decode stays stable while the command runs
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            req_r <= '0;
            valid_r <= 1'b0;
        end
        else if (REQ_VALID_IN)
        begin
            req_r <= dec_w;
            valid_r <= 1'b1;
        end
    end

    // execution gate: select needs selected state, address needs match
    wire exec_w = valid_r & ~req_r.unsupported
        & (~req_r.select_only | SELECTED_STATE_IN)
        & (~req_r.addressed | SERIAL_MATCH_IN);

    assign TWO_SUBCARRIERS_OUT = req_r.two_subcarriers;
    assign HIGH_RATE_OUT = req_r.high_rate;
    assign INVENTORY_OUT = req_r.inventory;
    assign SELECT_ONLY_OUT = req_r.select_only;
    assign SERIAL_PRESENT_OUT = req_r.addressed;
    assign OPTION_ON_OUT = req_r.option_on;
    assign FAMILY_FIELD_PRESENT_OUT = req_r.family_field_present;
    assign SLOT_COUNT_SELECT_OUT = req_r.single_slot;
    assign SLOT_COUNT_OUT = req_r.slot_count;
    assign EXECUTE_OUT = exec_w;
    assign UNSUPPORTED_OUT = valid_r & req_r.unsupported;

    // ************************************************************
    // response side
    // ************************************************************
    rrf_state_t st_r;
    rrf_state_t st_nxt;
    logic err_r;
    logic [7:0] code_r;
    logic load_w;
    logic [7:0] load_byte_w;
    logic adv_w;
    logic last_w;
    logic bit_w;

    // only the error flag may be one; extension stays zero
    wire [7:0] resp_flags_w = {7'h00, RESP_ERROR_IN};
    // an unsupported request forces the option error code
    wire [7:0] code_sel_w = UNSUPPORTED_OUT ? RRF_ERR_OPTION : RESP_ERR_CODE_IN;

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            st_r <= RRF_IDLE;
            err_r <= 1'b0;
            code_r <= RRF_FLAGS_RST;
        end
        else
        begin
            st_r <= st_nxt;
            if (st_r == RRF_IDLE && RESP_START_IN)
            begin
                err_r <= RESP_ERROR_IN;
                code_r <= code_sel_w;
            end
        end
    end

    // flags byte first, then error code only when flagged
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            RRF_IDLE:
            begin
                if (RESP_START_IN)
                    st_nxt = RRF_FLAGS;
            end
            RRF_FLAGS:
            begin
                if (adv_w && last_w)
                    st_nxt = err_r ? RRF_CODE : RRF_DONE;
            end
            RRF_CODE:
            begin
                if (adv_w && last_w)
                    st_nxt = RRF_DONE;
            end
            RRF_DONE:
            begin
                st_nxt = RRF_IDLE;
            end
            default:
            begin
                st_nxt = RRF_IDLE;
            end
        endcase
    end

    assign load_w = (st_r == RRF_IDLE && RESP_START_IN)
        || (st_r == RRF_FLAGS && adv_w && last_w && err_r);
    assign load_byte_w = (st_r == RRF_IDLE) ? resp_flags_w : code_r;
    assign BIT_VALID_OUT = (st_r == RRF_FLAGS) || (st_r == RRF_CODE);
    assign adv_w = BIT_VALID_OUT & BIT_READY_IN;

    rrf_bit_shifter u_sh (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .load_in(load_w),
        .byte_in(load_byte_w),
        .adv_in(adv_w),
        .bit_out(bit_w),
        .last_out(last_w)
    );

    assign BIT_DATA_OUT = bit_w;
    assign BYTE_LAST_OUT = BIT_VALID_OUT & last_w;
    assign RESP_DONE_OUT = (st_r == RRF_DONE);
    assign RESP_BUSY_OUT = (st_r != RRF_IDLE);

    // ************************************************************
    // checks
    // ************************************************************
    property p_subcarrier;
        @(posedge CLK_IN) disable iff (SRST_IN)
        REQ_VALID_IN |=> (TWO_SUBCARRIERS_OUT == $past(REQ_FLAGS_IN[RQ_SUBCARRIER_POS]));
    endproperty
    a_subcarrier: assert property (p_subcarrier) else $error("subcarrier wrong");

    property p_rate;
        @(posedge CLK_IN) disable iff (SRST_IN)
        REQ_VALID_IN |=> (HIGH_RATE_OUT == $past(REQ_FLAGS_IN[RQ_DATA_RATE_POS]));
    endproperty
    a_rate: assert property (p_rate) else $error("rate wrong");

    property p_nibble;
        @(posedge CLK_IN) disable iff (SRST_IN)
        INVENTORY_OUT |-> !SELECT_ONLY_OUT && !SERIAL_PRESENT_OUT && !OPTION_ON_OUT;
    endproperty
    a_nibble: assert property (p_nibble) else $error("nibble meaning mixed");

    property p_select;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (SELECT_ONLY_OUT && !SELECTED_STATE_IN) |-> !EXECUTE_OUT;
    endproperty
    a_select: assert property (p_select) else $error("executed unselected");

    property p_match;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (SERIAL_PRESENT_OUT && !SERIAL_MATCH_IN) |-> !EXECUTE_OUT;
    endproperty
    a_match: assert property (p_match) else $error("executed without match");

    property p_family;
        @(posedge CLK_IN) disable iff (SRST_IN)
        REQ_VALID_IN |=> FAMILY_FIELD_PRESENT_OUT
            == $past(REQ_FLAGS_IN[RQ_INVENTORY_POS] & REQ_FLAGS_IN[RQ_UPPER5_POS]);
    endproperty
    a_family: assert property (p_family) else $error("family flag wrong");

    property p_slots;
        @(posedge CLK_IN) disable iff (SRST_IN)
        REQ_VALID_IN |=> SLOT_COUNT_OUT
            == ($past(REQ_FLAGS_IN[RQ_UPPER6_POS]) ? RRF_SLOTS_ONE : RRF_SLOTS_MANY);
    endproperty
    a_slots: assert property (p_slots) else $error("slot count wrong");

    property p_reserved;
        @(posedge CLK_IN) disable iff (SRST_IN)
        REQ_VALID_IN && REQ_FLAGS_IN[RQ_RESERVED_POS] |=> UNSUPPORTED_OUT;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit accepted");

    property p_flags_byte;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (st_r == RRF_IDLE && RESP_START_IN) |=>
            BIT_VALID_OUT && BIT_DATA_OUT == $past(RESP_ERROR_IN);
    endproperty
    a_flags_byte: assert property (p_flags_byte) else $error("error flag bit wrong");

    property p_zero_bits;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (st_r == RRF_FLAGS && adv_w) |=> (st_r != RRF_FLAGS) || !BIT_DATA_OUT;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("upper response bit set");

    property p_opt_code;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (st_r == RRF_IDLE && RESP_START_IN && UNSUPPORTED_OUT) |=> code_r == RRF_ERR_OPTION;
    endproperty
    a_opt_code: assert property (p_opt_code) else $error("option code wrong");

    // a refused combination must never let the command run
    property p_no_exec_unsup;
        @(posedge CLK_IN) disable iff (SRST_IN)
        UNSUPPORTED_OUT |-> !EXECUTE_OUT;
    endproperty
    a_no_exec_unsup: assert property (p_no_exec_unsup) else $error("refused request ran");

    property p_option;
        @(posedge CLK_IN) disable iff (SRST_IN)
        REQ_VALID_IN |=> OPTION_ON_OUT
            == $past(!REQ_FLAGS_IN[RQ_INVENTORY_POS] && REQ_FLAGS_IN[RQ_OPTION_POS]);
    endproperty
    a_option: assert property (p_option) else $error("option flag wrong");

    property p_resp_order;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (st_r == RRF_FLAGS && BYTE_LAST_OUT && adv_w && !err_r) |=> RESP_DONE_OUT;
    endproperty
    a_resp_order: assert property (p_resp_order) else $error("clean response not ended");

    property p_code_follows;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (st_r == RRF_FLAGS && BYTE_LAST_OUT && adv_w && err_r) |=>
            st_r == RRF_CODE && BIT_VALID_OUT;
    endproperty
    a_code_follows: assert property (p_code_follows) else $error("error code missing");

    // a start while busy is dropped, so the captured context must not move
    property p_busy_hold;
        @(posedge CLK_IN) disable iff (SRST_IN)
        (RESP_BUSY_OUT && RESP_START_IN) |=> $stable(err_r) && $stable(code_r);
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("start taken while busy");

    property p_done_pulse;
        @(posedge CLK_IN) disable iff (SRST_IN)
        RESP_DONE_OUT |=> !RESP_DONE_OUT && !RESP_BUSY_OUT;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not one cycle");

    c_inventory: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
        INVENTORY_OUT && SLOT_COUNT_SELECT_OUT);
    c_error_resp: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
        st_r == RRF_CODE && BYTE_LAST_OUT && adv_w);
    c_clean_resp: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
        RESP_DONE_OUT && !err_r);
    c_unsupported: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
        UNSUPPORTED_OUT && RESP_START_IN && !RESP_BUSY_OUT);

endmodule : rrf_flags_top
`default_nettype wire

// ### rrf_pkg.sv
// ************************************************************
// request / response flag layout
// ************************************************************
package rrf_pkg;

    localparam int RRF_FLAG_W = 8;

    // request flag positions (flag bit n sits at byte bit n-1)
    localparam int RQ_SUBCARRIER_POS = 0;
    localparam int RQ_DATA_RATE_POS = 1;
    localparam int RQ_INVENTORY_POS = 2;
    localparam int RQ_EXTENSION_POS = 3;
    localparam int RQ_UPPER5_POS = 4;
    localparam int RQ_UPPER6_POS = 5;
    localparam int RQ_OPTION_POS = 6;
    localparam int RQ_RESERVED_POS = 7;

    // response flag positions
    localparam int RS_ERROR_POS = 0;
    localparam int RS_EXTENSION_POS = 3;

    // reset values and codes
    localparam logic [7:0] RRF_FLAGS_RST = 8'h00;
    localparam logic [7:0] RRF_ERR_OPTION = 8'h03;
    localparam logic [7:0] RRF_ERR_NONE_GIVEN = 8'h0f;
    localparam logic [4:0] RRF_SLOTS_MANY = 5'h10;
    localparam logic [4:0] RRF_SLOTS_ONE = 5'h01;
    localparam logic [2:0] RRF_BIT_LAST = 3'h7;

    // decoded view of a request flag byte
    typedef struct packed {
        logic two_subcarriers;
        logic high_rate;
        logic inventory;
        logic select_only;
        logic addressed;
        logic option_on;
        logic family_field_present;
        logic single_slot;
        logic [4:0] slot_count;
        logic unsupported;
    } rrf_req_t;

    // serialiser states, gray along the error-response path
    typedef enum logic [1:0] {
        RRF_IDLE = 2'b00,
        RRF_FLAGS = 2'b01,
        RRF_CODE = 2'b11,
        RRF_DONE = 2'b10
    } rrf_state_t;

endpackage : rrf_pkg

// ### rrf_reader_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// reader side bit sink
// ****************
module rrf_reader_model
    import rrf_pkg::*;
(
    // clock and control
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic clr_in,
    input wire logic slow_in,
    // tag bit stream
    input wire logic bit_valid_in,
    input wire logic bit_data_in,
    output logic bit_ready_out,
    // collected response
    output logic [15:0] word_out,
    output logic [4:0] count_out
);
    logic [1:0] stall_r;

    // slow mode takes one bit in four, so each bit must stand while stalled
    assign bit_ready_out = !slow_in || (stall_r == 2'h3);

    // bits enter at the msb; after sixteen bits the first sits in the low byte's lsb
    always_ff @(posedge clk_in)
    begin
        if (srst_in || clr_in)
        begin
            stall_r <= 2'h0;
            word_out <= 16'h0000;
            count_out <= 5'h00;
        end
        else
        begin
            stall_r <= stall_r + 2'h1;
            if (bit_valid_in && bit_ready_out)
            begin
                word_out <= {bit_data_in, word_out[15:1]};
                count_out <= count_out + 5'h01;
            end
        end
    end
endmodule : rrf_reader_model
`default_nettype wire

// ### rrf_req_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// request flag decoder, purely combinational
// ************************************************************
module rrf_req_decode
    import rrf_pkg::*;
(
    // flag byte
    input wire logic [7:0] flags_in,
    // decoded
    output rrf_req_t req_out
);

    wire inv_w = flags_in[RQ_INVENTORY_POS];
    wire b5_w = flags_in[RQ_UPPER5_POS];
    wire b6_w = flags_in[RQ_UPPER6_POS];

    // upper nibble meaning hinges on the inventory bit
    assign req_out.two_subcarriers = flags_in[RQ_SUBCARRIER_POS];
    assign req_out.high_rate = flags_in[RQ_DATA_RATE_POS];
    assign req_out.inventory = inv_w;
    assign req_out.select_only = ~inv_w & b5_w;
    assign req_out.addressed = ~inv_w & b6_w;
    assign req_out.option_on = ~inv_w & flags_in[RQ_OPTION_POS];
    assign req_out.family_field_present = inv_w & b5_w;
    assign req_out.single_slot = inv_w & b6_w;
    assign req_out.slot_count = b6_w ? RRF_SLOTS_ONE : RRF_SLOTS_MANY;
    // extension, reserved bit, option in inventory, select with address: refused
    assign req_out.unsupported = flags_in[RQ_EXTENSION_POS] | flags_in[RQ_RESERVED_POS]
        | (inv_w & flags_in[RQ_OPTION_POS]) | (~inv_w & b5_w & b6_w);

endmodule : rrf_req_decode
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); miscompares++; end end
// ****************
// flag decode and response bench
// ****************
module tb_top
    import rrf_pkg::*;
;
    logic CLK_IN, SRST_IN, REQ_VALID_IN, SELECTED_STATE_IN, SERIAL_MATCH_IN;
    logic [7:0] REQ_FLAGS_IN, RESP_ERR_CODE_IN;
    logic RESP_START_IN, RESP_ERROR_IN, slow_r, clr_r, bit_ready;
    logic TWO_SC, HI, INV, SELO, SERP, OPT, FAM, SCS, EXE, UNS;
    logic BUSY, VLD, DAT, LAST, DONE;
    logic [4:0] SLOTS, cnt;
    logic [15:0] word;
    wire logic [14:0] dec_w;
    int tests_run = 0;
    int miscompares = 0;
    int cycles = 0;

    assign dec_w = {TWO_SC, HI, INV, SELO, SERP, OPT, FAM, SCS, SLOTS, EXE, UNS};

    rrf_flags_top rrf_flags_top_inst (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN),
        .REQ_VALID_IN(REQ_VALID_IN), .REQ_FLAGS_IN(REQ_FLAGS_IN),
        .SELECTED_STATE_IN(SELECTED_STATE_IN), .SERIAL_MATCH_IN(SERIAL_MATCH_IN),
        .TWO_SUBCARRIERS_OUT(TWO_SC), .HIGH_RATE_OUT(HI), .INVENTORY_OUT(INV),
        .SELECT_ONLY_OUT(SELO), .SERIAL_PRESENT_OUT(SERP), .OPTION_ON_OUT(OPT),
        .FAMILY_FIELD_PRESENT_OUT(FAM), .SLOT_COUNT_SELECT_OUT(SCS),
        .SLOT_COUNT_OUT(SLOTS), .EXECUTE_OUT(EXE), .UNSUPPORTED_OUT(UNS),
        .RESP_START_IN(RESP_START_IN), .RESP_ERROR_IN(RESP_ERROR_IN),
        .RESP_ERR_CODE_IN(RESP_ERR_CODE_IN), .RESP_BUSY_OUT(BUSY),
        .BIT_READY_IN(bit_ready), .BIT_VALID_OUT(VLD), .BIT_DATA_OUT(DAT),
        .BYTE_LAST_OUT(LAST), .RESP_DONE_OUT(DONE));

    rrf_reader_model rrf_reader_model_inst (.clk_in(CLK_IN), .srst_in(SRST_IN),
        .clr_in(clr_r), .slow_in(slow_r), .bit_valid_in(VLD), .bit_data_in(DAT),
        .bit_ready_out(bit_ready), .word_out(word), .count_out(cnt));

    // 125 MHz
    initial
    begin
        CLK_IN = 1'b0;
        forever #4 CLK_IN = ~CLK_IN;
    end

    // expected decode of {match, selected, flags}
    function automatic logic [14:0] exp_dec(input logic [9:0] v);
        logic [7:0] f;
        logic u, so, sp;
        f = v[7:0];
        so = !f[2] && f[4];
        sp = !f[2] && f[5];
        u = f[3] || f[7] || (f[2] && f[6]) || (so && f[5]);
        return {f[0], f[1], f[2], so, sp, !f[2] && f[6], f[2] && f[4], f[2] && f[5],
            f[5] ? RRF_SLOTS_ONE : RRF_SLOTS_MANY, !u && (!so || v[8]) && (!sp || v[9]), u};
    endfunction : exp_dec

    task automatic wrap_up();
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // hold keeps the valid strobe up for a back-to-back follow-on
    task automatic req(input logic [9:0] v, input logic hold);
        @(posedge CLK_IN);
        REQ_VALID_IN <= 1'b1;
        REQ_FLAGS_IN <= v[7:0];
        SELECTED_STATE_IN <= v[8];
        SERIAL_MATCH_IN <= v[9];
        @(posedge CLK_IN);
        REQ_VALID_IN <= hold;
        #1;
        `CHK(dec_w, exp_dec(v))
    endtask : req

    // start a response, retrigger while busy, then collect it
    task automatic resp(input logic err, input logic [7:0] code, input logic slow,
        input logic [15:0] exp, input int nb);
        int n;
        int lasts;
        lasts = 0;
        @(posedge CLK_IN);
        RESP_START_IN <= 1'b1;
        RESP_ERROR_IN <= err;
        RESP_ERR_CODE_IN <= code;
        slow_r <= slow;
        clr_r <= 1'b1;
        @(posedge CLK_IN);
        RESP_START_IN <= 1'b0;
        RESP_ERROR_IN <= !err;
        RESP_ERR_CODE_IN <= ~code;
        clr_r <= 1'b0;
        @(posedge CLK_IN);
        RESP_START_IN <= 1'b1;
        @(posedge CLK_IN);
        RESP_START_IN <= 1'b0;
        for (n = 0; n < 400 && DONE !== 1'b1; n++)
        begin
            @(negedge CLK_IN);
            if ((VLD & bit_ready & LAST) === 1'b1)
                lasts++;
        end
        `CHK(DONE, 1'b1)
        `CHK(cnt, 5'(nb))
        `CHK(word, exp)
        `CHK(lasts, nb / 8)
        @(negedge CLK_IN);
        `CHK({DONE, VLD}, 2'b00)
        repeat (3) @(negedge CLK_IN);
        `CHK(BUSY, 1'b0)
    endtask : resp

    // hang guard, the whole run needs about 2200 cycles
    always @(posedge CLK_IN)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            $display("[ERR] t=%0t timeout", $time);
            miscompares++;
            wrap_up();
        end
    end

    initial
    begin
        SRST_IN = 1'b1;
        {REQ_VALID_IN, SELECTED_STATE_IN, SERIAL_MATCH_IN, RESP_START_IN} = 4'h0;
        {RESP_ERROR_IN, slow_r, clr_r} = 3'h0;
        REQ_FLAGS_IN = 8'h00;
        RESP_ERR_CODE_IN = 8'h00;
        repeat (3) @(posedge CLK_IN);
        SRST_IN <= 1'b0;
        #1;
        `CHK(dec_w, 15'h0000)
        resp(1'b0, 8'h0f, 1'b0, 16'h0000, 8);
        // every flag byte, including the reader's illegal ones, with context
        for (int i = 0; i < 1024; i++)
            req(i[9:0], i < 1023);
        repeat (3) @(negedge CLK_IN);
        `CHK(dec_w, exp_dec(10'h3ff))
        resp(1'b1, 8'h12, 1'b1, 16'h0301, 16);
        req(10'h002, 1'b0);
        resp(1'b1, 8'h0f, 1'b1, 16'h0f01, 16);
        @(posedge CLK_IN);
        SRST_IN <= 1'b1;
        @(posedge CLK_IN);
        SRST_IN <= 1'b0;
        #1;
        `CHK(dec_w, 15'h0000)
        `CHK({BUSY, VLD, DONE}, 3'b000)
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
